//--- inc/opseq_pkg.sv
// constants and types for the operand cycle sequencer
package opseq_pkg;
	localparam int          MCLK_PERIOD_NS  = 4;
	localparam int          HALF_CYCLE_NS   = 475;
	localparam int          MACHINE_CYC_NS  = 950;
	localparam int          OPND_START_NS   = 950;
	localparam int          NEXT_INSTR_NS   = 1900;
	localparam int          QUARTERS        = 4;
	localparam int          HALF_QUARTERS   = 2;
	localparam int          QTR_NS          = MACHINE_CYC_NS / QUARTERS;
	localparam int          QTR_CYCLES_I    = (QTR_NS / MCLK_PERIOD_NS) < 1 ? 1 : (QTR_NS / MCLK_PERIOD_NS);
	localparam logic [7:0]  QTR_CYCLES      = 8'(QTR_CYCLES_I);
	localparam logic [7:0]  DIV_RESET       = 8'h00;
	localparam logic [1:0]  QTR_RESET       = 2'h0;
	localparam logic [1:0]  QTR_HALF        = 2'(HALF_QUARTERS);
	localparam logic [1:0]  QTR_LAST        = 2'(QUARTERS - 1);
	localparam logic [15:0] WORD_RESET      = 16'h0000;
	localparam int          ADDR_MSB        = 14;
	localparam int          INDIRECT_BIT    = 15;
	typedef enum logic [1:0] {
		EXEC_NONE,
		EXEC_LOAD,
		EXEC_ADD,
		EXEC_STORE
	} exec_kind_t;
endpackage

//--- logic/operand_cycle_sequencer.sv
// memory cycle sequencer: fetch, operand, store and indirect address cycles
`timescale 1ns/1ps
`default_nettype none
// Operation
// - execute previous instruction during fetch of the current one
// - load fetched word into instruction register at 475 ns
// - form operand address while instruction word is restored
// - direct operand cycle begins at 950 ns, no address cycle
// - after operand read, load incremented program counter into address register
// - next instruction cycle begins at 1900 ns for direct operand
// - operate on fetched operand in next instruction's execute phase
// - store: selected register goes to write data in the fetch's address phase; location cleared in first half
// - store second half: write operand, form next instruction address
// - store instructions have no separate execute phase afterwards
// - indirect operand: address cycle reads address word first
// - indirect: form address word location, read word into operand register
// - repeat address cycles while the word read is again indirect
// - final address cycle second half loads resolved operand address
// - each memory cycle occupies one 950 ns machine cycle
// - first half reads or clears, second half restores or writes
module operand_cycle_sequencer
	import opseq_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        runEnable,
	input  wire logic [15:0] memReadData,
	output logic [15:0]      memAddr,
	output logic [15:0]      memWriteData,
	output logic             memReadClear,
	output logic             memRestoreWrite,
	output logic             memWriteMode,
	output logic             instr_cycle_phase,
	output logic             instr_exec_phase,
	output logic             instr_addr_phase,
	output logic             operand_cycle_phase,
	output logic             indirect_addr_cycle_phase,
	output logic [15:0]      instrReg,
	output logic [15:0]      operandReg,
	output logic [15:0]      progCounter,
	output logic [15:0]      accFirst,
	output logic [15:0]      accSecond,
	output logic [15:0]      indexReg
);
	typedef enum logic [1:0] {
		CYC_INSTR,
		CYC_ADDR,
		CYC_OPND
	} cyc_t;

	logic       qtrTick;
	logic [1:0] quarter;
	logic       runSync1;
	logic       runSync2;
	cyc_t       cycle;
	cyc_t       next_cycle;
	exec_kind_t pendingExec;
	logic [1:0] regSel;
	logic [15:0] curWord;
	logic       endOfCycle;
	logic       halfPoint;
	logic       isStore;
	logic       isIndirect;
	exec_kind_t decodedKind;
	logic [1:0] next_quarter;
	cyc_t       next_cycleState;

	quarter_timer u_timer (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.qtrTick (qtrTick),
		.quarter (quarter)
	);

	////////////////////////////////////////////////////////////////////////
	// run pin is asynchronous, so two flops before use
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			runSync1 <= 1'b0;
			runSync2 <= 1'b0;
		end else begin
			runSync1 <= runEnable;
			runSync2 <= runSync1;
		end
	end

	assign endOfCycle = qtrTick && (quarter == QTR_LAST);
	assign halfPoint  = qtrTick && (quarter == QTR_HALF - 2'h1);
	// opcode decode: bits 13:12 pick kind, bits 11:10 pick register
	assign decodedKind = exec_kind_t'(instrReg[13:12]);
	assign isStore     = (instrReg[13:12] == 2'h3);
	assign isIndirect  = instrReg[INDIRECT_BIT];
	assign curWord     = memReadData;
	assign next_quarter    = qtrTick ? quarter + 2'h1 : quarter;
	assign next_cycleState = (endOfCycle && runSync2) ? next_cycle : cycle;

	////////////////////////////////////////////////////////////////////////
	// cycle sequencing
	always_comb begin
		next_cycle = cycle;
		unique case (cycle)
			CYC_INSTR: next_cycle = isIndirect ? CYC_ADDR : CYC_OPND;
			CYC_ADDR:  next_cycle = operandReg[INDIRECT_BIT] ? CYC_ADDR : CYC_OPND;
			CYC_OPND:  next_cycle = CYC_INSTR;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn)
			cycle <= CYC_INSTR;
		else if (endOfCycle && runSync2)
			cycle <= next_cycle;
	end

	////////////////////////////////////////////////////////////////////////
	// phase outputs
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			instr_cycle_phase         <= 1'b0;
			operand_cycle_phase       <= 1'b0;
			indirect_addr_cycle_phase <= 1'b0;
			instr_exec_phase          <= 1'b0;
			instr_addr_phase          <= 1'b0;
			memReadClear              <= 1'b0;
			memRestoreWrite           <= 1'b0;
			memWriteMode              <= 1'b0;
		end else begin
			// outputs show the state after this edge, so a write half never meets a moved address
			instr_cycle_phase         <= runSync2 && next_cycleState == CYC_INSTR;
			operand_cycle_phase       <= runSync2 && next_cycleState == CYC_OPND;
			indirect_addr_cycle_phase <= runSync2 && next_cycleState == CYC_ADDR;
			// execute overlaps the fetch half of the instruction cycle
			instr_exec_phase <= runSync2 && next_cycleState == CYC_INSTR && next_quarter < QTR_HALF
				&& pendingExec != EXEC_NONE && pendingExec != EXEC_STORE;
			instr_addr_phase <= runSync2 && next_cycleState == CYC_INSTR && next_quarter >= QTR_HALF;
			memReadClear     <= runSync2 && next_quarter < QTR_HALF;
			memRestoreWrite  <= runSync2 && next_quarter >= QTR_HALF;
			memWriteMode     <= runSync2 && next_cycleState == CYC_OPND && isStore;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// datapath transfers at half, three-quarter and end of cycle
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			instrReg     <= WORD_RESET;
			operandReg   <= WORD_RESET;
			progCounter  <= WORD_RESET;
			memAddr      <= WORD_RESET;
			memWriteData <= WORD_RESET;
			pendingExec  <= EXEC_NONE;
			regSel       <= 2'h0;
		end else if (runSync2 && halfPoint) begin
			unique case (cycle)
				CYC_INSTR: begin
					instrReg <= curWord;
				end
				CYC_ADDR: begin
					operandReg <= curWord;
				end
				CYC_OPND: begin
					if (!isStore) begin
						operandReg <= curWord;
						memAddr    <= progCounter + 16'h0001;
					end
					progCounter <= progCounter + 16'h0001;
				end
			endcase
		end else if (runSync2 && qtrTick && quarter == QTR_HALF) begin
			unique case (cycle)
				CYC_INSTR: begin
					// operand or address word location formed in address phase
					memAddr <= {1'b0, instrReg[ADDR_MSB:0]};
					pendingExec <= decodedKind;
					regSel <= instrReg[11:10];
					if (isStore)
						memWriteData <= instrReg[11:10] == 2'h0 ? accFirst :
							instrReg[11:10] == 2'h1 ? accSecond : indexReg;
				end
				CYC_ADDR: begin
					memAddr <= {1'b0, operandReg[ADDR_MSB:0]};
				end
				CYC_OPND: begin
				end
			endcase
		end else if (runSync2 && endOfCycle && cycle == CYC_OPND && isStore) begin
			// store keeps the cleared location until its write half is over
			memAddr <= progCounter;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// execute phase of the following cycle uses the held operand
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			accFirst  <= WORD_RESET;
			accSecond <= WORD_RESET;
			indexReg  <= WORD_RESET;
		end else if (runSync2 && cycle == CYC_INSTR && qtrTick && quarter == QTR_RESET) begin
			unique case (pendingExec)
				EXEC_LOAD: begin
					if (regSel == 2'h0)
						accFirst <= operandReg;
					else if (regSel == 2'h1)
						accSecond <= operandReg;
					else
						indexReg <= operandReg;
				end
				EXEC_ADD:  accFirst <= accFirst + operandReg;
				EXEC_NONE, EXEC_STORE: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_fetch_end;
		endOfCycle && runSync2 && cycle == CYC_INSTR;
	endsequence

	a_direct_to_operand: assert property (@(posedge sys_clk) disable iff (!resetn)
		(s_fetch_end and !isIndirect) |=> cycle == CYC_OPND)
		else $error("direct fetch not followed by operand cycle");
	a_indirect_to_addr: assert property (@(posedge sys_clk) disable iff (!resetn)
		(s_fetch_end and isIndirect) |=> cycle == CYC_ADDR)
		else $error("indirect fetch not followed by address cycle");
	a_chain_repeats: assert property (@(posedge sys_clk) disable iff (!resetn)
		endOfCycle && runSync2 && cycle == CYC_ADDR && operandReg[INDIRECT_BIT] |=> cycle == CYC_ADDR)
		else $error("indirect chain not followed");
	a_opnd_to_fetch: assert property (@(posedge sys_clk) disable iff (!resetn)
		endOfCycle && runSync2 && cycle == CYC_OPND |=> cycle == CYC_INSTR)
		else $error("operand cycle not followed by fetch");
	a_instr_load: assert property (@(posedge sys_clk) disable iff (!resetn)
		halfPoint && runSync2 && cycle == CYC_INSTR |=> instrReg == $past(memReadData))
		else $error("instruction word not loaded at half cycle");
	a_pc_advance: assert property (@(posedge sys_clk) disable iff (!resetn)
		halfPoint && runSync2 && cycle == CYC_OPND |=> progCounter == $past(progCounter) + 16'h0001
		&& (isStore ? memAddr == $past(memAddr) : memAddr == progCounter))
		else $error("next instruction address not formed");
	a_store_next_addr: assert property (@(posedge sys_clk) disable iff (!resetn)
		endOfCycle && runSync2 && cycle == CYC_OPND && isStore |=> memAddr == progCounter)
		else $error("next address not loaded after store");
	a_store_addr_steady: assert property (@(posedge sys_clk) disable iff (!resetn)
		memWriteMode && $past(memWriteMode) |-> memAddr == $past(memAddr))
		else $error("address moved during store cycle");
	a_halves_exclusive: assert property (@(posedge sys_clk) disable iff (!resetn)
		!(memReadClear && memRestoreWrite))
		else $error("read and restore halves overlap");
	a_store_no_exec: assert property (@(posedge sys_clk) disable iff (!resetn)
		pendingExec == EXEC_STORE |=> !instr_exec_phase)
		else $error("store given an execute phase");
	a_quarter_spacing: assert property (@(posedge sys_clk) disable iff (!resetn)
		qtrTick |=> !qtrTick)
		else $error("quarter strobes too close");
endmodule
`default_nettype wire

//--- logic/quarter_timer.sv
// master clock divider producing quarter strobe and quarter count
`timescale 1ns/1ps
`default_nettype none
module quarter_timer
	import opseq_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	output logic            qtrTick,
	output logic [1:0]      quarter
);
	logic [7:0] divCount;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			divCount <= DIV_RESET;
			qtrTick  <= 1'b0;
		end else if (divCount == QTR_CYCLES - 8'h01) begin
			divCount <= DIV_RESET;
			qtrTick  <= 1'b1;
		end else begin
			divCount <= divCount + 8'h01;
			qtrTick  <= 1'b0;
		end
	end

	// four quarters per machine cycle, half boundary after two
	always_ff @(posedge sys_clk) begin
		if (!resetn)
			quarter <= QTR_RESET;
		else if (qtrTick)
			quarter <= quarter + 2'h1;
	end
endmodule
`default_nettype wire

//--- test/mem_model.sv
// main memory model: read-restore and clear-write halves
`timescale 1ns/1ps
`default_nettype none
module mem_model (
	input  wire logic        sys_clk,
	input  wire logic [15:0] memAddr,
	input  wire logic [15:0] memWriteData,
	input  wire logic        memReadClear,
	input  wire logic        memRestoreWrite,
	input  wire logic        memWriteMode,
	output logic [15:0]      memReadData
);
	logic [15:0] mem [0:255];
	logic [15:0] junk = 16'hA5A5;
	// released data lines toggle so a late sample never sees a good word
	always @(posedge sys_clk) begin
		junk <= ~junk;
		if (memReadClear && memWriteMode) begin
			mem[memAddr[7:0]] <= 16'h0000;
		end
		if (memRestoreWrite && memWriteMode) begin
			mem[memAddr[7:0]] <= memWriteData;
		end
	end
	assign memReadData = (memReadClear && !memWriteMode) ? mem[memAddr[7:0]] : junk;
endmodule
`default_nettype wire

//--- test/tb_top.sv
// testbench: short program run through the sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
	compares++; \
	if ((g) !== (e)) begin \
		nFail++; \
		$display("BAD %s exp %0h got %0h", nm, e, g); \
	end \
end
module tb_top;
	import opseq_pkg::*;
	localparam int MC = 4 * QTR_CYCLES_I;
	// first walk starts three edges after the timer, whose first quarter runs 60 edges, one more than the usual 59
	localparam int START_LAG = 2;
	logic        sys_clk, resetn, runEnable;
	logic [15:0] memReadData, memAddr, memWriteData, instrReg, operandReg;
	logic [15:0] progCounter, accFirst, accSecond, indexReg, ir;
	logic        memReadClear, memRestoreWrite, memWriteMode, ex, rc, rw, wm, ac, iap;
	logic        instr_cycle_phase, instr_exec_phase, instr_addr_phase;
	logic        operand_cycle_phase, indirect_addr_cycle_phase;
	int          nFail = 0;
	int          compares = 0;
	int          tick = 0;
	int          tOp, tNx;
	operand_cycle_sequencer operand_cycle_sequencer_i (.sys_clk, .resetn, .runEnable, .memReadData, .memAddr,
		.memWriteData, .memReadClear, .memRestoreWrite, .memWriteMode, .instr_cycle_phase, .instr_exec_phase,
		.instr_addr_phase, .operand_cycle_phase, .indirect_addr_cycle_phase, .instrReg, .operandReg,
		.progCounter, .accFirst, .accSecond, .indexReg);
	mem_model mem_model_i (.sys_clk, .memAddr, .memWriteData, .memReadClear, .memRestoreWrite,
		.memWriteMode, .memReadData);
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		tick <= tick + 1;
		if (tick == 12000) begin
			nFail++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", compares, nFail);
		if (nFail == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// follows one instruction cycle from its first clock to the next fetch
	task automatic walk();
		int n;
		logic prev;
		n = 0;
		prev = 1'b1;
		tOp = 0;
		tNx = 0;
		while (tNx == 0 && n < 1200) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (n == 30) ex = instr_exec_phase;
			if (n == 60) rc = memReadClear;
			if (n == 125) ir = instrReg;
			if (n == 180) rw = memRestoreWrite;
			if (n == 180) iap = instr_addr_phase;
			if (n == 300) wm = memWriteMode;
			if (n == 300) ac = indirect_addr_cycle_phase;
			if (operand_cycle_phase && tOp == 0) tOp = n;
			if (instr_cycle_phase && !prev) tNx = n;
			prev = instr_cycle_phase;
		end
	endtask
	task automatic t_load_direct();
		walk();
		`CHK("ir", 16'h1010, ir)
		`CHK("rd", 1'b1, rc)
		`CHK("wr", 1'b1, rw)
		`CHK("opnd", MC - START_LAG, tOp)
		`CHK("next", 2 * MC - START_LAG, tNx)
		`CHK("pcaddr", 16'h0001, memAddr)
		`CHK("aphase", 1'b1, iap)
		`CHK("wmode", 1'b0, wm)
	endtask
	task automatic t_add_direct();
		walk();
		`CHK("ir", 16'h2011, ir)
		`CHK("exec", 1'b1, ex)
		`CHK("accld", 16'h1234, accFirst)
		`CHK("noaddr", 1'b0, ac)
		`CHK("next", 2 * MC, tNx)
	endtask
	task automatic t_store();
		walk();
		`CHK("ir", 16'h3012, ir)
		`CHK("accadd", 16'h1335, accFirst)
		`CHK("opnd", MC, tOp)
		`CHK("next", 2 * MC, tNx)
		`CHK("stored", 16'h1335, mem_model_i.mem[8'h12])
		`CHK("wmode", 1'b1, wm)
		`CHK("wdata", 16'h1335, memWriteData)
		`CHK("nextins", 16'h3010, mem_model_i.mem[8'h03] ^ 16'hA803)
	endtask
	task automatic t_indirect();
		walk();
		`CHK("ir", 16'h9813, ir)
		`CHK("noexec", 1'b0, ex)
		`CHK("opnd", 3 * MC, tOp)
		`CHK("next", 4 * MC, tNx)
		`CHK("pcaddr", 16'h0004, memAddr)
		`CHK("pc", 16'h0004, progCounter)
		`CHK("acyc", 1'b1, ac)
		`CHK("opreg", 16'h0101, operandReg)
	endtask
	task automatic t_none();
		walk();
		`CHK("exec", 1'b1, ex)
		`CHK("index", 16'h0101, indexReg)
		`CHK("accb", 16'h0000, accSecond)
	endtask
	// run level low must hold program counter and address register still
	task automatic t_freeze();
		logic [15:0] pc, ad;
		runEnable <= 1'b0;
		repeat (5) @(posedge sys_clk);
		#1;
		pc = progCounter;
		ad = memAddr;
		repeat (300) @(posedge sys_clk);
		#1;
		`CHK("pchold", pc, progCounter)
		`CHK("adhold", ad, memAddr)
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		resetn = 1'b0;
		runEnable = 1'b0;
		for (int i = 0; i < 256; i++) mem_model_i.mem[i] = 16'h0000;
		mem_model_i.mem[0] = 16'h1010;
		mem_model_i.mem[1] = 16'h2011;
		mem_model_i.mem[2] = 16'h3012;
		mem_model_i.mem[3] = 16'h9813;
		mem_model_i.mem[8'h10] = 16'h1234;
		mem_model_i.mem[8'h11] = 16'h0101;
		mem_model_i.mem[8'h13] = 16'h8014;
		mem_model_i.mem[8'h14] = 16'h0011;
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		runEnable <= 1'b1;
		while (instr_cycle_phase !== 1'b1) begin
			@(posedge sys_clk);
			#1;
		end
		t_load_direct();
		t_add_direct();
		t_store();
		t_indirect();
		t_none();
		t_freeze();
		final_report();
	end
endmodule
`default_nettype wire
